// ==== hdl/swpl_pkg.sv ====
package swpl_pkg;

  localparam int CLK_MHZ = 20;
  localparam int CW      = 14;

  // Least times round up, longest times round down, never below one cycle
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_dn(input int ns);
    int c;
    c = (ns * CLK_MHZ) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  // Reset low durations seen by the peripheral
  localparam int RST_EXIT_OD_NS   = 480000;
  localparam int RST_KEEP_OD_NS   = 80000;
  localparam int LOW_RST_STD_NS   = 120000;
  localparam int LOW_RST_OD_NS    = 15500;
  // Peripheral timing generator
  localparam int PRES_WAIT_STD_NS = 30000;
  localparam int PRES_WAIT_OD_NS  = 3000;
  localparam int PRES_LOW_STD_NS  = 120000;
  localparam int PRES_LOW_OD_NS   = 12000;
  localparam int SAMPLE_STD_NS    = 30000;
  localparam int SAMPLE_OD_NS     = 3000;
  localparam int RD_HOLD_STD_NS   = 30000;
  localparam int RD_HOLD_OD_NS    = 3000;
  // Controller waveforms
  localparam int RSTL_STD_NS      = 480000;
  localparam int RSTL_OD_NS       = 70000;
  localparam int RSTH_STD_NS      = 480000;
  localparam int RSTH_OD_NS       = 48000;
  localparam int MSP_STD_NS       = 70000;
  localparam int MSP_OD_NS        = 8500;
  localparam int W1L_STD_NS       = 6000;
  localparam int W1L_OD_NS        = 1000;
  localparam int W0L_STD_NS       = 60000;
  localparam int W0L_OD_NS        = 7500;
  localparam int RL_STD_NS        = 6000;
  localparam int RL_OD_NS         = 1000;
  localparam int MSR_STD_NS       = 12000;
  localparam int MSR_OD_NS        = 1500;
  localparam int SLOT_STD_NS      = 70000;
  localparam int SLOT_OD_NS       = 10000;

  localparam logic [CW-1:0] KEEP_OD_CYC   = CW'(cyc_dn(RST_KEEP_OD_NS));
  localparam logic [CW-1:0] LOW_RST_STD   = CW'(cyc_up(LOW_RST_STD_NS));
  localparam logic [CW-1:0] LOW_RST_OD    = CW'(cyc_up(LOW_RST_OD_NS));
  localparam logic [CW-1:0] PW_STD        = CW'(cyc_up(PRES_WAIT_STD_NS));
  localparam logic [CW-1:0] PW_OD         = CW'(cyc_up(PRES_WAIT_OD_NS));
  localparam logic [CW-1:0] PL_STD        = CW'(cyc_up(PRES_LOW_STD_NS));
  localparam logic [CW-1:0] PL_OD         = CW'(cyc_up(PRES_LOW_OD_NS));
  localparam logic [CW-1:0] SMP_STD       = CW'(cyc_up(SAMPLE_STD_NS));
  localparam logic [CW-1:0] SMP_OD        = CW'(cyc_up(SAMPLE_OD_NS));
  localparam logic [CW-1:0] HOLD_STD      = CW'(cyc_up(RD_HOLD_STD_NS));
  localparam logic [CW-1:0] HOLD_OD       = CW'(cyc_up(RD_HOLD_OD_NS));
  localparam logic [CW-1:0] RSTL_OD       = CW'(cyc_up(RSTL_OD_NS));
  localparam logic [CW-1:0] RSTH_OD       = CW'(cyc_up(RSTH_OD_NS));
  localparam logic [CW-1:0] MSP_STD       = CW'(cyc_dn(MSP_STD_NS));
  localparam logic [CW-1:0] MSP_OD        = CW'(cyc_dn(MSP_OD_NS));
  localparam logic [CW-1:0] W1L_STD       = CW'(cyc_dn(W1L_STD_NS));
  localparam logic [CW-1:0] W1L_OD        = CW'(cyc_dn(W1L_OD_NS));
  localparam logic [CW-1:0] W0L_STD       = CW'(cyc_up(W0L_STD_NS));
  localparam logic [CW-1:0] W0L_OD        = CW'(cyc_up(W0L_OD_NS));
  localparam logic [CW-1:0] RL_STD        = CW'(cyc_dn(RL_STD_NS));
  localparam logic [CW-1:0] RL_OD         = CW'(cyc_dn(RL_OD_NS));
  localparam logic [CW-1:0] MSR_STD       = CW'(cyc_dn(MSR_STD_NS));
  localparam logic [CW-1:0] MSR_OD        = CW'(cyc_dn(MSR_OD_NS));
  localparam logic [CW-1:0] SLOT_STD      = CW'(cyc_up(SLOT_STD_NS));
  localparam logic [CW-1:0] SLOT_OD       = CW'(cyc_up(SLOT_OD_NS));

  localparam logic [7:0]  ROM_OD_SKIP = 8'h3c;
  localparam logic [15:0] CRC_POLY_R  = 16'ha001;
  localparam logic [15:0] CRC_INIT    = 16'h0000;

  typedef enum logic [1:0] {CMD_RESET, CMD_WRITE, CMD_READ} swpl_cmd_t;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    return (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY_R : 16'h0000);
  endfunction

endpackage

// ==== hdl/swpl_if.sv ====
`timescale 1ns/10ps
interface swpl_if;
  logic dev_out;
  logic dev_oe;
  logic ctl_out;
  logic ctl_oe;
  logic line;

  // Open-drain wired-AND with pullup
  assign line = ~((dev_oe & ~dev_out) | (ctl_oe & ~ctl_out));

  modport dev (input line, output dev_out, output dev_oe);
  modport ctl (input line, output ctl_out, output ctl_oe);
endinterface

// ==== hdl/swpl_dev.sv ====
`timescale 1ns/10ps
module swpl_dev #(
  parameter logic [13:0] EXIT_OD_CYC = 14'(swpl_pkg::cyc_up(swpl_pkg::RST_EXIT_OD_NS))
) (
  // Clock and reset
  input  wire logic        REF_CLK_IN,
  input  wire logic        RST_N_IN,
  // Line
  swpl_if.dev              LINE,
  // Received bytes
  output logic             RX_VALID_OUT,
  output logic [7:0]       RX_DATA_OUT,
  input  wire logic        RX_READY_IN,
  // Bytes to return in read slots
  input  wire logic        TX_VALID_IN,
  input  wire logic [7:0]  TX_DATA_IN,
  output logic             TX_READY_OUT,
  // Status
  output logic             OD_OUT,
  output logic             ROM_PHASE_OUT,
  output logic             RESET_SEEN_OUT,
  input  wire logic        CRC_CLR_IN,
  output logic [15:0]      CRC_OUT
);

  typedef enum logic [2:0] {D_IDLE, D_SLOT, D_RSTL, D_PWAIT, D_PLOW, D_PREL} swpl_dst_t;

  typedef struct packed {
    logic            s1;
    logic            s2;
    logic            prev;
    swpl_dst_t       st;
    logic [13:0]     cnt;
    logic            od;
    logic            odp;
    logic            rom;
    logic [3:0]      nbit;
    logic [7:0]      sh;
    logic            pend;
    logic [7:0]      tx;
    logic            txb;
    logic            drv;
    logic [15:0]     crc;
    logic [1:0][7:0] mem;
    logic            wp;
    logic            rp;
    logic [1:0]      fill;
    logic            rst_seen;
  } swpl_dev_t;

  swpl_dev_t q;
  swpl_dev_t d;

  logic        fall;
  logic        push;
  logic        pop;
  logic        bitv;
  logic [13:0] t_smp;
  logic [13:0] t_hold;
  logic [13:0] t_lrst;
  logic [13:0] t_pw;
  logic [13:0] t_pl;

  // Speed-scaled timing
  always_comb begin
    t_smp  = q.od ? swpl_pkg::SMP_OD : swpl_pkg::SMP_STD;
    t_hold = q.od ? swpl_pkg::HOLD_OD : swpl_pkg::HOLD_STD;
    t_lrst = q.od ? swpl_pkg::LOW_RST_OD : swpl_pkg::LOW_RST_STD;
    t_pw   = q.od ? swpl_pkg::PW_OD : swpl_pkg::PW_STD;
    t_pl   = q.od ? swpl_pkg::PL_OD : swpl_pkg::PL_STD;
  end

  assign fall = q.prev & ~q.s2;
  assign pop  = RX_READY_IN && (q.fill != 2'd0);

  always_comb begin
    d        = q;
    push     = 1'b0;
    bitv     = q.s2;
    d.s1     = LINE.line;
    d.s2     = q.s1;
    d.prev   = q.s2;
    d.rst_seen = 1'b0;
    if (q.cnt != 14'h3fff) begin
      d.cnt = q.cnt + 14'h0001;
    end
    if (q.pend && q.fill != 2'd2) begin
      push   = 1'b1;
      d.pend = 1'b0;
    end
    case (q.st)
      D_IDLE: begin
        if (fall) begin
          d.st  = D_SLOT;
          d.cnt = 14'h0000;
          d.drv = q.txb & ~q.tx[0];
        end
      end
      D_SLOT: begin
        if (q.drv && q.cnt == t_hold) begin
          d.drv = 1'b0;
        end
        if (q.cnt == t_smp && !(q.pend && !q.txb)) begin
          d.nbit = q.nbit + 4'h1;
          if (q.txb) begin
            d.tx = {1'b1, q.tx[7:1]};
            if (q.nbit == 4'h7) begin
              d.txb  = 1'b0;
              d.nbit = 4'h0;
            end
          end else begin
            d.sh = {bitv, q.sh[7:1]};
            if (q.nbit == 4'h7) begin
              d.nbit = 4'h0;
              if (q.rom) begin
                d.rom = 1'b0;
                // Speed switches only once this slot has ended
                if ({bitv, q.sh[7:1]} == swpl_pkg::ROM_OD_SKIP) begin
                  d.odp = 1'b1;
                end
              end else begin
                d.pend = 1'b1;
              end
            end
          end
          if (!q.rom) begin
            d.crc = swpl_pkg::crc_step(q.crc, bitv);
          end
        end
        if (q.s2 && q.cnt > t_smp) begin
          d.st  = D_IDLE;
          d.od  = q.od | q.odp;
          d.odp = 1'b0;
        end else if (!q.s2 && q.cnt >= t_lrst) begin
          d.st  = D_RSTL;
          d.drv = 1'b0;
        end
      end
      D_RSTL: begin
        if (q.s2) begin
          if (q.cnt >= EXIT_OD_CYC) begin
            d.od = 1'b0;
          end else if (q.od && q.cnt <= swpl_pkg::KEEP_OD_CYC) begin
            d.od = 1'b1;
          end
          d.rom      = 1'b1;
          d.odp      = 1'b0;
          d.nbit     = 4'h0;
          d.txb      = 1'b0;
          d.pend     = 1'b0;
          d.rst_seen = 1'b1;
          d.st       = D_PWAIT;
          d.cnt      = 14'h0000;
        end
      end
      D_PWAIT: begin
        if (q.cnt >= t_pw) begin
          d.st  = D_PLOW;
          d.drv = 1'b1;
          d.cnt = 14'h0000;
        end
      end
      D_PLOW: begin
        if (q.cnt >= t_pl) begin
          d.st  = D_PREL;
          d.drv = 1'b0;
        end
      end
      D_PREL: begin
        if (q.s2) begin
          d.st = D_IDLE;
        end
      end
      default: begin
        d.st  = D_IDLE;
        d.drv = 1'b0;
      end
    endcase
    if (TX_VALID_IN && TX_READY_OUT) begin
      d.tx  = TX_DATA_IN;
      d.txb = 1'b1;
    end
    if (push) begin
      d.mem[q.wp] = q.sh;
      d.wp        = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.fill = q.fill + {1'b0, push} - {1'b0, pop};
    if (CRC_CLR_IN) begin
      d.crc = swpl_pkg::CRC_INIT;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      q     <= '0;
      q.s1  <= 1'b1;
      q.s2  <= 1'b1;
      q.prev <= 1'b1;
      q.st  <= D_IDLE;
      q.rom <= 1'b1;
      q.crc <= swpl_pkg::CRC_INIT;
    end else begin
      q <= d;
    end
  end

  assign LINE.dev_out   = 1'b0;
  assign LINE.dev_oe    = q.drv;
  assign RX_VALID_OUT   = (q.fill != 2'd0);
  assign RX_DATA_OUT    = q.mem[q.rp];
  assign TX_READY_OUT   = (q.st == D_IDLE) && !q.txb && !q.rom && (q.nbit == 4'h0) && !q.pend;
  assign OD_OUT         = q.od;
  assign ROM_PHASE_OUT  = q.rom;
  assign RESET_SEEN_OUT = q.rst_seen;
  assign CRC_OUT        = q.crc;

endmodule

// ==== hdl/swpl_ctl.sv ====
`timescale 1ns/10ps
module swpl_ctl #(
  parameter logic [13:0] RSTL_STD_CYC = 14'(swpl_pkg::cyc_up(swpl_pkg::RSTL_STD_NS)),
  parameter logic [13:0] RSTH_STD_CYC = 14'(swpl_pkg::cyc_up(swpl_pkg::RSTH_STD_NS))
) (
  // Clock and reset
  input  wire logic              REF_CLK_IN,
  input  wire logic              RST_N_IN,
  // Line
  swpl_if.ctl                    LINE,
  // Commands
  input  wire logic              CMD_VALID_IN,
  input  wire swpl_pkg::swpl_cmd_t CMD_IN,
  input  wire logic [7:0]        CMD_DATA_IN,
  input  wire logic              OD_IN,
  output logic                   CMD_READY_OUT,
  // Results
  output logic                   DONE_OUT,
  output logic                   PRESENT_OUT,
  output logic [7:0]             RD_DATA_OUT,
  input  wire logic              CRC_CLR_IN,
  output logic [15:0]            CRC_OUT
);

  typedef enum logic [1:0] {C_IDLE, C_RLOW, C_RHIGH, C_SLOT} swpl_cst_t;

  typedef struct packed {
    logic        s1;
    logic        s2;
    swpl_cst_t   st;
    logic [13:0] cnt;
    logic        od;
    logic        rd;
    logic [2:0]  nbit;
    logic [7:0]  sh;
    logic        smp;
    logic        oe;
    logic        pres;
    logic [7:0]  rdat;
    logic        done;
    logic [15:0] crc;
  } swpl_ctl_t;

  swpl_ctl_t q;
  swpl_ctl_t d;

  logic [13:0] t_low;
  logic [13:0] t_msr;
  logic [13:0] t_slot;
  logic        bitv;

  always_comb begin
    if (q.rd) begin
      t_low = q.od ? swpl_pkg::RL_OD : swpl_pkg::RL_STD;
    end else if (q.sh[0]) begin
      t_low = q.od ? swpl_pkg::W1L_OD : swpl_pkg::W1L_STD;
    end else begin
      t_low = q.od ? swpl_pkg::W0L_OD : swpl_pkg::W0L_STD;
    end
    t_msr  = q.od ? swpl_pkg::MSR_OD : swpl_pkg::MSR_STD;
    t_slot = q.od ? swpl_pkg::SLOT_OD : swpl_pkg::SLOT_STD;
  end

  assign bitv = q.rd ? q.smp : q.sh[0];

  always_comb begin
    d      = q;
    d.s1   = LINE.line;
    d.s2   = q.s1;
    d.done = 1'b0;
    d.cnt  = q.cnt + 14'h0001;
    case (q.st)
      C_IDLE: begin
        if (CMD_VALID_IN) begin
          d.od   = OD_IN;
          d.cnt  = 14'h0000;
          d.oe   = 1'b1;
          d.rd   = (CMD_IN == swpl_pkg::CMD_READ);
          d.sh   = (CMD_IN == swpl_pkg::CMD_READ) ? 8'hff : CMD_DATA_IN;
          d.nbit = 3'h0;
          d.st   = (CMD_IN == swpl_pkg::CMD_RESET) ? C_RLOW : C_SLOT;
        end
      end
      C_RLOW: begin
        if (q.cnt >= (q.od ? swpl_pkg::RSTL_OD : RSTL_STD_CYC)) begin
          d.oe  = 1'b0;
          d.cnt = 14'h0000;
          d.st  = C_RHIGH;
        end
      end
      C_RHIGH: begin
        if (q.cnt == (q.od ? swpl_pkg::MSP_OD : swpl_pkg::MSP_STD)) begin
          d.pres = ~q.s2;
        end
        if (q.cnt >= (q.od ? swpl_pkg::RSTH_OD : RSTH_STD_CYC)) begin
          d.done = 1'b1;
          d.st   = C_IDLE;
        end
      end
      C_SLOT: begin
        if (q.cnt == t_low) begin
          d.oe = 1'b0;
        end
        if (q.cnt == t_msr) begin
          d.smp = q.s2;
        end
        if (q.cnt >= t_slot) begin
          d.sh   = {bitv, q.sh[7:1]};
          d.crc  = swpl_pkg::crc_step(q.crc, bitv);
          d.nbit = q.nbit + 3'h1;
          d.cnt  = 14'h0000;
          if (q.nbit == 3'h7) begin
            d.rdat = {bitv, q.sh[7:1]};
            d.done = 1'b1;
            d.st   = C_IDLE;
          end else begin
            d.oe = 1'b1;
          end
        end
      end
      default: begin
        d.st = C_IDLE;
        d.oe = 1'b0;
      end
    endcase
    if (CRC_CLR_IN) begin
      d.crc = swpl_pkg::CRC_INIT;
    end
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      q     <= '0;
      q.s1  <= 1'b1;
      q.s2  <= 1'b1;
      q.st  <= C_IDLE;
      q.crc <= swpl_pkg::CRC_INIT;
    end else begin
      q <= d;
    end
  end

  assign LINE.ctl_out  = 1'b0;
  assign LINE.ctl_oe   = q.oe;
  assign CMD_READY_OUT = (q.st == C_IDLE);
  assign DONE_OUT      = q.done;
  assign PRESENT_OUT   = q.pres;
  assign RD_DATA_OUT   = q.rdat;
  assign CRC_OUT       = q.crc;

endmodule

// ==== bench/swpl_link_sva.sv ====
`timescale 1ns/10ps
module swpl_link_sva #(
  parameter logic [13:0] RSTL_STD_CYC = 14'h0bb8
) (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RST_N_IN,
  // Line
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic ctl_out,
  input wire logic ctl_oe,
  input wire logic line
);
  typedef struct packed {
    logic [13:0] hi;
    logic [13:0] drun;
    logic [13:0] crun;
    logic        rd;
  } swpl_sva_st_t;

  swpl_sva_st_t st_q;
  swpl_sva_st_t st_d;

  // High time, pull run lengths, read pull flag
  always_comb begin
    st_d      = st_q;
    st_d.hi   = !line ? 14'h0000 : (&st_q.hi ? st_q.hi : st_q.hi + 14'h0001);
    st_d.drun = dev_oe ? st_q.drun + 14'h0001 : 14'h0000;
    st_d.crun = ctl_oe ? st_q.crun + 14'h0001 : 14'h0000;
    st_d.rd   = dev_oe ? ((st_q.drun == 14'h0000) ? ctl_oe : st_q.rd) : 1'b0;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (!RST_N_IN) begin
      st_q <= {14'h3fff, 29'h00000000};
    end else begin
      st_q <= st_d;
    end
  end

  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);

  a_open_drain: assert property (!dev_out && !ctl_out)
    else $error("line data driven high");
  a_wired_level: assert property (line == !(dev_oe || ctl_oe))
    else $error("line level not wired and");
  a_reset_release: assert property ($rose(RST_N_IN) |-> !dev_oe && !ctl_oe)
    else $error("line pulled right after reset");
  a_dev_own_fall: assert property ($rose(dev_oe) |-> ctl_oe || st_q.hi >= 14'd32)
    else $error("device started a fall outside presence");
  a_pull_min: assert property ($fell(dev_oe) |-> st_q.drun >= 14'd56)
    else $error("device pull released too early");
  a_read_pull_max: assert property (dev_oe && st_q.rd |-> st_q.drun <= 14'd604)
    else $error("read zero pull too long");
  a_presence_len: assert property (dev_oe |-> st_q.drun <= 14'd2404)
    else $error("presence pull too long");
  a_ctl_low_max: assert property (ctl_oe |-> st_q.crun <= RSTL_STD_CYC + 14'd2)
    else $error("controller low too long");
  a_slot_recovery: assert property ($rose(ctl_oe) |-> st_q.hi >= 14'd20)
    else $error("slot started without recovery");
  a_presence_after: assert property ($fell(ctl_oe) && st_q.crun >= 14'd1300 |->
    ##[1:700] dev_oe)
    else $error("no presence after reset low");

  c_reset_low: cover property ($fell(ctl_oe) && st_q.crun >= 14'd1300);
  c_read_zero: cover property ($rose(dev_oe) && ctl_oe);
  c_presence: cover property ($rose(dev_oe) && !ctl_oe);
endmodule

// ==== bench/test_single_wire_peripheral_link.sv ====
`timescale 1ns/10ps
module test_single_wire_peripheral_link;
  logic                clk;
  logic                rst_n;
  logic                cmd_valid;
  swpl_pkg::swpl_cmd_t cmd;
  logic [7:0]          cmd_data;
  logic                od;
  logic                spd;
  logic                cmd_ready;
  logic                done;
  logic                present;
  logic [7:0]          rd_data;
  logic [15:0]         ctl_crc;
  logic                rx_ready;
  logic                rx_valid;
  logic [7:0]          rx_data;
  logic                tx_valid;
  logic [7:0]          tx_data;
  logic                tx_ready;
  logic                od_dev;
  logic                rom_phase;
  logic                rst_seen;
  logic                crc_clr;
  logic [15:0]         dev_crc;
  logic [31:0]         rnd;
  logic [15:0]         crc;
  logic [7:0]          w [3];
  int                  bad_count;
  int                  cmp_count;
  int                  seen_n = 0;

  swpl_if i_swpl_if();

  swpl_dev #(.EXIT_OD_CYC(14'h0bb8)) i_swpl_dev (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .LINE(i_swpl_if.dev),
    .RX_VALID_OUT(rx_valid), .RX_DATA_OUT(rx_data), .RX_READY_IN(rx_ready),
    .TX_VALID_IN(tx_valid), .TX_DATA_IN(tx_data), .TX_READY_OUT(tx_ready),
    .OD_OUT(od_dev), .ROM_PHASE_OUT(rom_phase), .RESET_SEEN_OUT(rst_seen),
    .CRC_CLR_IN(crc_clr), .CRC_OUT(dev_crc));

  swpl_ctl #(.RSTL_STD_CYC(14'h0bb8), .RSTH_STD_CYC(14'h0e10)) i_swpl_ctl (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .LINE(i_swpl_if.ctl),
    .CMD_VALID_IN(cmd_valid), .CMD_IN(cmd), .CMD_DATA_IN(cmd_data), .OD_IN(od),
    .CMD_READY_OUT(cmd_ready), .DONE_OUT(done), .PRESENT_OUT(present),
    .RD_DATA_OUT(rd_data), .CRC_CLR_IN(crc_clr), .CRC_OUT(ctl_crc));

  swpl_link_sva #(.RSTL_STD_CYC(14'h0bb8)) i_swpl_link_sva (
    .REF_CLK_IN(clk), .RST_N_IN(rst_n), .dev_out(i_swpl_if.dev_out),
    .dev_oe(i_swpl_if.dev_oe), .ctl_out(i_swpl_if.ctl_out),
    .ctl_oe(i_swpl_if.ctl_oe), .line(i_swpl_if.line));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rst_seen === 1'b1)
      seen_n++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [7:0] rbyte();
    rnd = lfsr(rnd);
    return rnd[7:0];
  endfunction

  // Random ROM byte that never enters overdrive
  function automatic logic [7:0] nrom();
    logic [7:0] b;
    b = rbyte();
    return (b == swpl_pkg::ROM_OD_SKIP) ? ~b : b;
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    for (int i = 0; i < 8; i++)
      c = (c >> 1) ^ ((c[0] ^ b[i]) ? swpl_pkg::CRC_POLY_R : 16'h0000);
    return c;
  endfunction

  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic miss(input logic [15:0] got, input logic [15:0] exp);
    bad_count++;
    $display("ERROR at %0t: got %h expected %h", $time, got, exp);
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
      miss({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
      miss(got, exp);
  endtask

  task automatic wait_lim(input int n, input int lim);
    if (n >= lim) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic cmd_go(input swpl_pkg::swpl_cmd_t c, input logic [7:0] d);
    int n;
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd = c;
    cmd_data = d;
    od = spd;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    wait_lim(n, 100);
    @(negedge clk);
    cmd_valid = 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20000);
    wait_lim(n, 20000);
  endtask

  task automatic wr(input logic [7:0] d);
    cmd_go(swpl_pkg::CMD_WRITE, d);
    crc = crc_byte(crc, d);
  endtask

  task automatic rd(input logic [7:0] d);
    int n;
    @(negedge clk);
    tx_valid = 1'b1;
    tx_data = d;
    n = 0;
    while (tx_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    wait_lim(n, 100);
    @(negedge clk);
    tx_valid = 1'b0;
    cmd_go(swpl_pkg::CMD_READ, 8'h00);
    chk_val({8'h00, rd_data}, {8'h00, d});
    crc = crc_byte(crc, d);
  endtask

  task automatic pop(input logic [7:0] e);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rx_valid !== 1'b1 && n < 100);
    wait_lim(n, 100);
    chk_val({8'h00, rx_data}, {8'h00, e});
    rx_ready = 1'b1;
    @(negedge clk);
    rx_ready = 1'b0;
  endtask

  // Reset, ROM byte, drop any ROM echo, restart both CRCs
  task automatic sess(input logic o, input logic [7:0] rom);
    spd = o;
    cmd_go(swpl_pkg::CMD_RESET, 8'h00);
    chk_flag(present, 1'b1);
    chk_flag(rom_phase, 1'b1);
    cmd_go(swpl_pkg::CMD_WRITE, rom);
    chk_flag(rom_phase, 1'b0);
    @(negedge clk);
    rx_ready = 1'b1;
    crc_clr = 1'b1;
    @(negedge clk);
    crc_clr = 1'b0;
    repeat (2) @(negedge clk);
    rx_ready = 1'b0;
    crc = swpl_pkg::CRC_INIT;
  endtask

  initial begin
    rst_n = 1'b0;
    cmd_valid = 1'b0;
    cmd = swpl_pkg::CMD_RESET;
    cmd_data = 8'h00;
    od = 1'b0;
    spd = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    crc_clr = 1'b0;
    rnd = 32'h69e2;
    crc = 16'h0000;
    bad_count = 0;
    cmp_count = 0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    chk_flag(od_dev, 1'b0);
    chk_val(dev_crc, 16'h0000);
    sess(1'b0, nrom());
    chk_flag(od_dev, 1'b0);
    w[0] = rbyte();
    wr(w[0]);
    pop(w[0]);
    rd(rbyte());
    chk_val(dev_crc, crc);
    chk_val(ctl_crc, crc);
    sess(1'b0, swpl_pkg::ROM_OD_SKIP);
    chk_flag(od_dev, 1'b1);
    sess(1'b1, nrom());
    chk_flag(od_dev, 1'b1);
    for (int i = 0; i < 3; i++)
      w[i] = rbyte();
    wr(w[0]);
    wr(w[1]);
    chk_val(dev_crc, crc);
    chk_val(ctl_crc, crc);
    wr(w[2]);
    pop(w[0]);
    pop(w[1]);
    pop(w[2]);
    chk_flag(rx_valid, 1'b0);
    rd(8'h00);
    rd(8'hff);
    spd = 1'b0;
    cmd_go(swpl_pkg::CMD_RESET, 8'h00);
    chk_flag(od_dev, 1'b0);
    chk_flag(present, 1'b1);
    chk_val(16'(seen_n), 16'h0004);
    conclude();
  end
endmodule
